// >>> hdl/can_error_count_and_id_filter.sv
// Bus-off hold flag, error count views and identifier acceptance filter.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "can_filter_cfg.svh"

// Operation
// RL1 - Writing one clears the hold flag; zero is ignored; readable anytime.
// RL2 - With user recovery selected, bus-off sets hold; clearing it requests recovery.
// RL3 - Receive error view at 0x000E shows internal count, read-only, resets zero.
// RL4 - Transmit error view at 0x000F shows internal count, read-only, resets zero.
// RL5 - Software reads error counts only in sleep or initialization mode.
// RL6 - Error count reads outside those modes need not be synchronised.
// RL7 - Every received frame lands in the background buffer before filtering.
// RL8 - Only accepted frames signal the CPU; rejected ones get overwritten.
// RL9 - Filter compares four identifier bytes with code bytes bit by bit.
// RL10 - Extended frames use all four code and mask bytes of a bank.
// RL11 - Standard frames use only the first two code and mask bytes.
// RL12 - Code registers read anytime, written only in initialization mode.
// RL13 - Each code byte compared with its identifier byte, then masked.
// RL14 - Second code bank sits at 0x0018 to 0x001B, resets to zero.
// RL15 - Mask bits select which code bits take part in acceptance.
// RL16 - Software sets low three mask bits of bytes one and five for standard.
// RL17 - Software sets low three mask bits of bytes 1,3,5,7 for 16-bit standard.
// RL18 - Mask zero needs equality, one ignores; accept when all compared bits match.
// RL19 - Organization selects 2x32, 4x16, 8x8 filters or closed.
// RL20 - Without user recovery the hold flag reads zero and writes do nothing.
module can_error_count_and_id_filter #(
  parameter int ID_BYTES = 4
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // Avalon-MM slave
  input  wire logic [7:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST,
  // Protocol engine side
  input  wire logic        INIT_ACKNOWLEDGE,
  input  wire logic        SLEEP_ACKNOWLEDGE,
  input  wire logic [7:0]  RECEIVE_ERROR_COUNT,
  input  wire logic [7:0]  TRANSMIT_ERROR_COUNT,
  input  wire logic        BUSOFF_ENTER,
  input  wire logic        FRAME_STORED,
  input  wire logic        FRAME_EXTENDED,
  input  wire logic [31:0] RECEIVED_IDENTIFIER_BYTES,
  // Results
  output logic             FRAME_ACCEPTED,
  output logic             FRAME_DROPPED,
  output logic [2:0]       HIT_FILTER,
  output logic             RECOVERY_REQUEST,
  output logic             INIT_REQUEST,
  output logic             SLEEP_REQUEST
);

  // ==========================================================================
  // Register map, by word index (the byte address is four times the index).
  // 0x0E holds the receive error count view, read only.
  // 0x0F holds the transmit error count view, read only.
  // 0x10 holds acceptance code bytes 0 to 3, byte lane b carrying code byte b.
  // 0x12 holds the control word.
  // 0x13 holds the bus-off hold flag in bit 0; writing one clears it.
  // 0x14 holds acceptance mask bytes 0 to 3.
  // 0x18 holds acceptance code bytes 4 to 7.
  // 0x1C holds acceptance mask bytes 4 to 7.
  // Every other index reads zero and ignores writes.
  // Control bits: 0 init request, 1 sleep request, 2 user recovery select,
  // 5:4 filter organization, 8 and 9 the synchronised init and sleep acknowledges.
  // Code, mask, organization and recovery select take writes only in init mode,
  // that is with the init request set and its acknowledge seen by the synchroniser.

  // ==========================================================================
  // Storage
  logic [7:0]                code_reg [0:7];
  logic [7:0]                mask_reg [0:7];
  logic [1:0]                org_reg;
  logic                      recovery_sel_reg;
  logic                      hold_reg;
  logic [1:0]                init_sync_reg;
  logic [1:0]                sleep_sync_reg;
  logic                      init_meta_reg;
  logic                      sleep_meta_reg;
  can_filter_pkg::bus_state_t bus_state_reg;
  logic [31:0]               rdata_next;
  logic                      pair_ok;

  wire logic [5:0] word_idx = ADDRESS[7:2];
  wire logic       init_mode = INIT_REQUEST && init_sync_reg[1] && init_sync_reg[0];
  wire logic       accept_cycle = (bus_state_reg == can_filter_pkg::BUS_WAIT);
  wire logic       wr_go = accept_cycle && WRITE;

  // Masked compare of one byte: true when every compared bit matches.
  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] code,
                                      input logic [7:0] mask);
    byte_match = &((~(id ^ code)) | mask); // RL13 RL15 RL18
  endfunction : byte_match

  // Accepted write to the low byte lane of one register word.
  function automatic logic wr_lane0(input logic [5:0] ofs);
    wr_lane0 = wr_go && (word_idx == ofs) && BYTEENABLE[0];
  endfunction : wr_lane0

  // ==========================================================================
  // Mode acknowledge synchronisers (acknowledges come from the bit-clock side).
  // Init mode counts as entered only once the last two stages agree, so a glitch
  // on an acknowledge cannot open the filter setup for a single cycle.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      init_meta_reg  <= 1'b0;
      sleep_meta_reg <= 1'b0;
      init_sync_reg  <= 2'b00;
      sleep_sync_reg <= 2'b00;
    end else begin
      init_meta_reg  <= INIT_ACKNOWLEDGE;
      sleep_meta_reg <= SLEEP_ACKNOWLEDGE;
      init_sync_reg  <= {init_sync_reg[0], init_meta_reg};
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_meta_reg};
    end
  end

  // ==========================================================================
  // Bus handshake: one wait cycle, answer in the second cycle.
  // The read word is captured on the taking edge, so it stands unchanged for the
  // whole answer cycle. The trailing BUS_DONE state keeps a request that is still
  // high at the answering edge from being taken a second time.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      bus_state_reg <= can_filter_pkg::BUS_IDLE;
      WAITREQUEST   <= 1'b1;
      READDATA      <= 32'h00000000;
    end else begin
      unique case (bus_state_reg)
        can_filter_pkg::BUS_IDLE: begin
          WAITREQUEST <= 1'b1;
          if (READ || WRITE) begin
            bus_state_reg <= can_filter_pkg::BUS_WAIT;
            WAITREQUEST   <= 1'b0;
            READDATA      <= rdata_next;
          end
        end
        can_filter_pkg::BUS_WAIT: begin
          bus_state_reg <= can_filter_pkg::BUS_DONE;
          WAITREQUEST   <= 1'b1;
        end
        can_filter_pkg::BUS_DONE: begin
          bus_state_reg <= can_filter_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_reg <= can_filter_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Error counts are shown unsynchronised; they are steady in sleep or init mode.
  // Reading them in any other mode may catch a count in the middle of a change,
  // which software is told to avoid; the extra synchroniser was not worth it.
  always_comb begin
    rdata_next = 32'h00000000;
    unique case (word_idx)
      `OFS_RX_ERR: rdata_next[7:0] = RECEIVE_ERROR_COUNT; // RL3 RL6
      `OFS_TX_ERR: rdata_next[7:0] = TRANSMIT_ERROR_COUNT; // RL4 RL6
      `OFS_MISC:   rdata_next[`BIT_HOLD] = hold_reg; // RL1
      `OFS_CTRL: begin
        rdata_next[`BIT_INIT_REQ]     = INIT_REQUEST;
        rdata_next[`BIT_SLEEP_REQ]    = SLEEP_REQUEST;
        rdata_next[`BIT_RECOVERY_SEL] = recovery_sel_reg;
        rdata_next[`POS_ORG +: 2]     = org_reg;
        rdata_next[8 + `BIT_INIT_ACK]  = init_sync_reg[1];
        rdata_next[8 + `BIT_SLEEP_ACK] = sleep_sync_reg[1];
      end
      `OFS_CODE_BANK0: rdata_next = {code_reg[3], code_reg[2], code_reg[1], code_reg[0]}; // RL12
      `OFS_CODE_BANK1: rdata_next = {code_reg[7], code_reg[6], code_reg[5], code_reg[4]}; // RL14
      `OFS_MASK_BANK0: rdata_next = {mask_reg[3], mask_reg[2], mask_reg[1], mask_reg[0]};
      `OFS_MASK_BANK1: rdata_next = {mask_reg[7], mask_reg[6], mask_reg[5], mask_reg[4]};
      default:         rdata_next = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Mode requests may be written in any mode; this is how software leaves init.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      INIT_REQUEST  <= 1'b1;
      SLEEP_REQUEST <= 1'b0;
    end else if (wr_lane0(`OFS_CTRL)) begin
      INIT_REQUEST  <= WRITEDATA[`BIT_INIT_REQ];
      SLEEP_REQUEST <= WRITEDATA[`BIT_SLEEP_REQ];
    end
  end

  // Organization and recovery select are frozen outside init mode, so a running
  // filter never sees a half-written setup.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      recovery_sel_reg <= 1'b0;
      org_reg          <= `RST_ORG;
    end else if (wr_lane0(`OFS_CTRL) && init_mode) begin // RL12
      recovery_sel_reg <= WRITEDATA[`BIT_RECOVERY_SEL];
      org_reg          <= WRITEDATA[`POS_ORG +: 2];
    end
  end

  // ==========================================================================
  // Acceptance code bytes change only in initialization mode.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) begin
        code_reg[i] <= `RST_BYTE; // RL14
      end
    end else if (wr_go && init_mode) begin // RL12
      for (int b = 0; b < 4; b++) begin
        if (BYTEENABLE[b] && word_idx == `OFS_CODE_BANK0) begin
          code_reg[b] <= WRITEDATA[8*b +: 8];
        end
        if (BYTEENABLE[b] && word_idx == `OFS_CODE_BANK1) begin
          code_reg[b + 4] <= WRITEDATA[8*b +: 8]; // RL14
        end
      end
    end
  end

  // Mask bytes follow the same rule; a set bit takes its code bit out of the compare.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) begin
        mask_reg[i] <= `RST_BYTE;
      end
    end else if (wr_go && init_mode) begin // RL12
      for (int b = 0; b < 4; b++) begin
        if (BYTEENABLE[b] && word_idx == `OFS_MASK_BANK0) begin
          mask_reg[b] <= WRITEDATA[8*b +: 8]; // RL15
        end
        if (BYTEENABLE[b] && word_idx == `OFS_MASK_BANK1) begin
          mask_reg[b + 4] <= WRITEDATA[8*b +: 8]; // RL15
        end
      end
    end
  end

  // ==========================================================================
  // Bus-off hold. Entering bus-off wins over a same-cycle clear.
  // Letting the clear win would start a recovery from a bus-off state that the
  // software has not seen yet; the lost clear is simply repeated by software.
  // The recovery request is a single pulse to the engine, raised only when the
  // flag was really set, so a stray write of one does not restart anything.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hold_reg         <= 1'b0;
      RECOVERY_REQUEST <= 1'b0;
    end else begin
      RECOVERY_REQUEST <= 1'b0;
      if (!recovery_sel_reg) begin
        hold_reg <= 1'b0; // RL20
      end else if (BUSOFF_ENTER) begin
        hold_reg <= 1'b1; // RL2
      end else if (wr_lane0(`OFS_MISC) && WRITEDATA[`BIT_HOLD] && hold_reg) begin
        hold_reg         <= 1'b0; // RL1
        RECOVERY_REQUEST <= 1'b1; // RL2
      end
    end
  end

  // ==========================================================================
  // Acceptance filter, evaluated once the frame sits in the background buffer.
  // Filters are scanned from the top down so that the lowest-numbered hit wins,
  // which is the filter the hit field then reports.
  // Identifier byte 0 travels in the top byte of the identifier bus.
  logic       hit_any;
  logic [2:0] hit_idx;
  logic [7:0] idb [0:3];

  always_comb begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    pair_ok = 1'b0;
    for (int k = 0; k < ID_BYTES; k++) begin
      idb[k] = RECEIVED_IDENTIFIER_BYTES[8*(3-k) +: 8]; // RL9
    end
    unique case (can_filter_pkg::filter_org_t'(org_reg)) // RL19
      can_filter_pkg::ORG_TWO_32: begin
        // Standard frames stop after the first two bytes of each bank.
        for (int f = 1; f >= 0; f--) begin
          pair_ok = byte_match(idb[0], code_reg[4*f], mask_reg[4*f])
                  && byte_match(idb[1], code_reg[4*f+1], mask_reg[4*f+1]); // RL11
          if (FRAME_EXTENDED) begin
            pair_ok = pair_ok && byte_match(idb[2], code_reg[4*f+2], mask_reg[4*f+2])
                    && byte_match(idb[3], code_reg[4*f+3], mask_reg[4*f+3]); // RL10
          end
          if (pair_ok) begin
            hit_any = 1'b1;
            hit_idx = 3'(f);
          end
        end
      end
      can_filter_pkg::ORG_FOUR_16: begin
        // Each filter is a code and mask pair laid over identifier bytes 0 and 1.
        for (int f = 3; f >= 0; f--) begin
          if (byte_match(idb[0], code_reg[2*f], mask_reg[2*f])
              && byte_match(idb[1], code_reg[2*f+1], mask_reg[2*f+1])) begin
            hit_any = 1'b1;
            hit_idx = 3'(f);
          end
        end
      end
      can_filter_pkg::ORG_EIGHT_8: begin
        // Each filter is one code and mask byte laid over identifier byte 0.
        for (int f = 7; f >= 0; f--) begin
          if (byte_match(idb[0], code_reg[f], mask_reg[f])) begin
            hit_any = 1'b1;
            hit_idx = 3'(f);
          end
        end
      end
      can_filter_pkg::ORG_CLOSED: hit_any = 1'b0; // RL19
    endcase
  end

  // The verdict follows the strobe by one cycle; the hit field keeps the last
  // accepted filter, so a dropped frame leaves it untouched.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FRAME_ACCEPTED <= 1'b0;
      FRAME_DROPPED  <= 1'b0;
      HIT_FILTER     <= 3'h0;
    end else begin
      FRAME_ACCEPTED <= FRAME_STORED && hit_any; // RL7 RL8
      FRAME_DROPPED  <= FRAME_STORED && !hit_any; // RL8
      if (FRAME_STORED && hit_any) begin
        HIT_FILTER <= hit_idx;
      end
    end
  end

  // Limitation: the filter keeps no history. A rejected frame leaves nothing
  // behind, and the engine must hold the identifier steady only in the strobe
  // cycle, because the next strobe simply overwrites the background buffer.

endmodule : can_error_count_and_id_filter

// >>> common/can_filter_cfg.svh
// Register offsets, field positions and reset values of the filter and error-count block.
`ifndef CAN_FILTER_CFG_SVH
`define CAN_FILTER_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define OFS_CODE_BANK0      6'h10
`define OFS_CTRL            6'h12
`define OFS_MISC            6'h13
`define OFS_RX_ERR          6'h0E
`define OFS_TX_ERR          6'h0F
`define OFS_CODE_BANK1      6'h18
`define OFS_MASK_BANK0      6'h14
`define OFS_MASK_BANK1      6'h1C

// ==========================================================================
// Field positions
`define BIT_HOLD            0
`define BIT_INIT_REQ        0
`define BIT_SLEEP_REQ       1
`define BIT_RECOVERY_SEL    2
`define POS_ORG             4
`define BIT_INIT_ACK        0
`define BIT_SLEEP_ACK       1

// ==========================================================================
// Reset values
`define RST_BYTE            8'h00
`define RST_ORG             2'h0

`endif

// >>> common/can_filter_pkg.sv
// Types shared by the filter and error-count block.
package can_filter_pkg;

  typedef enum logic [1:0] {
    ORG_TWO_32   = 2'b00,
    ORG_FOUR_16  = 2'b01,
    ORG_EIGHT_8  = 2'b10,
    ORG_CLOSED   = 2'b11
  } filter_org_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;

endpackage : can_filter_pkg

// >>> tb/can_filter_props.sv
// Port-level checker for the filter and error-count block.
`timescale 1ns/1ps
module can_filter_props (
  // Clock, reset and register bus
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic [7:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  // Engine side and results
  input wire logic [7:0]  RECEIVE_ERROR_COUNT,
  input wire logic [7:0]  TRANSMIT_ERROR_COUNT,
  input wire logic        FRAME_STORED,
  input wire logic        FRAME_ACCEPTED,
  input wire logic        FRAME_DROPPED,
  input wire logic [2:0]  HIT_FILTER,
  input wire logic        RECOVERY_REQUEST,
  input wire logic        INIT_REQUEST
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire       ack = !WAITREQUEST;
  wire [5:0] idx = ADDRESS[7:2];
  wire       wr_hold = WRITE && ack && idx == 6'h13 && WRITEDATA[0];
  // ==========================================================================
  // Properties
  property p_res; FRAME_STORED |=> FRAME_ACCEPTED ^ FRAME_DROPPED; endproperty
  property p_cause; FRAME_ACCEPTED || FRAME_DROPPED |-> $past(FRAME_STORED); endproperty
  property p_hit; $changed(HIT_FILTER) |-> FRAME_ACCEPTED; endproperty
  property p_rec; RECOVERY_REQUEST |-> $past(wr_hold) || $past(wr_hold, 2); endproperty
  property p_init; $changed(INIT_REQUEST) |-> $past(WRITE && ack && idx == 6'h12); endproperty
  property p_rx;
    READ && ack && idx == 6'h0E && $stable(RECEIVE_ERROR_COUNT)
      |-> READDATA[7:0] == RECEIVE_ERROR_COUNT;
  endproperty
  property p_tx;
    READ && ack && idx == 6'h0F && $stable(TRANSMIT_ERROR_COUNT)
      |-> READDATA[7:0] == TRANSMIT_ERROR_COUNT;
  endproperty
  property p_ans; ack |-> $past(READ || WRITE) ##1 WAITREQUEST; endproperty
  a_res: assert property (p_res) else $error("no single result");
  a_cause: assert property (p_cause) else $error("result without frame");
  a_hit: assert property (p_hit) else $error("hit moved without accept");
  a_rec: assert property (p_rec) else $error("recovery without clear");
  a_init: assert property (p_init) else $error("init request moved alone");
  a_rx: assert property (p_rx) else $error("receive count view wrong");
  a_tx: assert property (p_tx) else $error("transmit count view wrong");
  a_ans: assert property (p_ans) else $error("bad bus answer");
  c_acc: cover property (FRAME_ACCEPTED);
  c_drop: cover property (FRAME_DROPPED);
  c_rec: cover property (RECOVERY_REQUEST);
endmodule : can_filter_props

// >>> tb/can_node_model.sv
// Stand-in for the protocol engine and the other nodes on the bus.
`timescale 1ns/1ps
module can_node_model (
  // Clock
  input wire logic    MCLK,
  // Frame and bus-off events
  output logic        FRAME_STORED,
  output logic        FRAME_EXTENDED,
  output logic [31:0] RECEIVED_IDENTIFIER_BYTES,
  output logic        BUSOFF_ENTER
);
  initial begin
    FRAME_STORED = 1'b0;
    FRAME_EXTENDED = 1'b0;
    RECEIVED_IDENTIFIER_BYTES = 32'h0;
    BUSOFF_ENTER = 1'b0;
  end
  // The identifier is valid with the strobe only; scrambling it after exposes late sampling.
  task automatic send(input logic [31:0] id, input logic ext);
    FRAME_STORED <= 1'b1;
    FRAME_EXTENDED <= ext;
    RECEIVED_IDENTIFIER_BYTES <= id;
    @(posedge MCLK);
    FRAME_STORED <= 1'b0;
    FRAME_EXTENDED <= !ext;
    RECEIVED_IDENTIFIER_BYTES <= ~id;
  endtask : send
  task automatic busoff();
    BUSOFF_ENTER <= 1'b1;
    @(posedge MCLK);
    BUSOFF_ENTER <= 1'b0;
  endtask : busoff
endmodule : can_node_model

// >>> tb/tb_can_error_count_and_id_filter.sv
// Self-checking bench: register views, hold flag and acceptance filter.
`timescale 1ns/1ps
bind can_error_count_and_id_filter can_filter_props u_props (.*);
module tb_can_error_count_and_id_filter;
  logic             MCLK = 1'b0, RST = 1'b1, READ = 1'b0, WRITE = 1'b0;
  logic [7:0]       ADDRESS = 8'h00, RECEIVE_ERROR_COUNT = 8'h00, TRANSMIT_ERROR_COUNT = 8'h00;
  logic [31:0]      WRITEDATA = 32'h0, READDATA, RECEIVED_IDENTIFIER_BYTES, id;
  logic [3:0]       BYTEENABLE = 4'hF, f;
  logic             INIT_ACKNOWLEDGE = 1'b0, SLEEP_ACKNOWLEDGE = 1'b0, WAITREQUEST;
  logic             BUSOFF_ENTER, FRAME_STORED, FRAME_EXTENDED, FRAME_ACCEPTED, FRAME_DROPPED;
  logic             RECOVERY_REQUEST, INIT_REQUEST, SLEEP_REQUEST;
  logic [2:0]       HIT_FILTER;
  logic [7:0][7:0]  code, mask;
  logic [1:0]       org;
  logic             ext;
  logic [63:0]      e, rq[$];
  logic [3:0]       fq[$];
  int               n_fail = 0, checked = 0, n_rec = 0, b;
  can_error_count_and_id_filter dut (.*);
  can_node_model node (.*);
  always #4 MCLK = ~MCLK;
  // The engine acknowledges mode requests one cycle late.
  always @(posedge MCLK) begin
    INIT_ACKNOWLEDGE <= INIT_REQUEST;
    SLEEP_ACKNOWLEDGE <= SLEEP_REQUEST;
  end
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // ==========================================================================
  // Monitor
  always @(posedge MCLK) begin
    if (RECOVERY_REQUEST === 1'b1) n_rec++;
    if (READ === 1'b1 && WAITREQUEST === 1'b0) begin
      e = rq.size() ? rq.pop_front() : 64'h1;
      chk((READDATA & e[63:32]) === e[31:0], "read data");
    end
    if (FRAME_ACCEPTED === 1'b1 || FRAME_DROPPED === 1'b1) begin
      f = fq.size() ? fq.pop_front() : 4'h0;
      chk(FRAME_ACCEPTED === f[3] && (!f[3] || HIT_FILTER === f[2:0]), "filter");
    end
  end
  // ==========================================================================
  // Drivers and reference
  task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d);
    int n = 0;
    ADDRESS <= {i, 2'b00};
    WRITEDATA <= d;
    WRITE <= w;
    READ <= !w;
    do begin
      @(posedge MCLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_fail++;
      test_done();
    end
    READ <= 1'b0;
    WRITE <= 1'b0;
    @(posedge MCLK);
  endtask : bus
  task automatic rd(input logic [5:0] i, input logic [31:0] m, input logic [31:0] x);
    rq.push_back({m, x});
    bus(1'b0, i, 32'h0);
  endtask : rd
  function automatic logic [3:0] ref_f(input logic [31:0] v, input logic ext);
    int w;
    logic ok;
    w = (org == 2'b00) ? 4 : (org == 2'b01) ? 2 : 1;
    for (int k = 0; k < 8 / w; k++) begin
      ok = (org != 2'b11);
      for (int j = 0; j < w; j++)
        if (ext || org != 2'b00 || j < 2)
          ok &= ((v[31 - 8 * j -: 8] ^ code[w * k + j]) & ~mask[w * k + j]) == 8'h00;
      if (ok) return {1'b1, 3'(k)};
    end
    return 4'h0;
  endfunction : ref_f
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(41));
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    repeat (4) @(posedge MCLK);
    rd(6'h0E, 32'hFF, 32'h0);
    rd(6'h0F, 32'hFF, 32'h0);
    rd(6'h18, 32'hFFFFFFFF, 32'h0);
    rd(6'h3F, 32'hFFFFFFFF, 32'h0);
    rd(6'h12, 32'h101, 32'h101);
    node.busoff();
    rd(6'h13, 32'h1, 32'h0);
    $display("test reset done");
    RECEIVE_ERROR_COUNT <= 8'($urandom);
    TRANSMIT_ERROR_COUNT <= 8'($urandom);
    @(posedge MCLK);
    bus(1'b1, 6'h0E, 32'hFFFFFFFF);
    rd(6'h0E, 32'hFF, {24'h0, RECEIVE_ERROR_COUNT});
    rd(6'h0F, 32'hFF, {24'h0, TRANSMIT_ERROR_COUNT});
    bus(1'b1, 6'h12, 32'h3);
    repeat (6) @(posedge MCLK);
    rd(6'h12, 32'h303, 32'h303);
    rd(6'h0E, 32'hFF, {24'h0, RECEIVE_ERROR_COUNT});
    $display("test counts done");
    for (int i = 0; i < 8; i++) begin
      code[i] = 8'($urandom);
      mask[i] = (8'($urandom) & 8'h30) | ((i % 2) ? 8'h07 : 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 6'(8 * k + 16), code[4 * k +: 4]);
      bus(1'b1, 6'(8 * k + 20), mask[4 * k +: 4]);
    end
    for (int o = 0; o < 4; o++) begin
      org = 2'(o);
      bus(1'b1, 6'h12, {26'h0, org, 4'h5});
      bus(1'b1, 6'h12, {26'h0, org, 4'h4});
      repeat (4) @(posedge MCLK);
      bus(1'b1, 6'h18, ~code[7:4]);
      rd(6'h18, 32'hFFFFFFFF, code[7:4]);
      repeat (16) begin
        b = $urandom % 8;
        for (int k = 0; k < 4; k++)
          id[31 - 8 * k -: 8] = code[(b + k) % 8] ^ (($urandom % 3) ? 8'h00 : 8'($urandom));
        ext = 1'($urandom);
        fq.push_back(ref_f(id, ext));
        node.send(id, ext);
        @(posedge MCLK);
      end
      bus(1'b1, 6'h12, 32'h5);
      repeat (4) @(posedge MCLK);
    end
    $display("test filter done");
    node.busoff();
    rd(6'h13, 32'h1, 32'h1);
    bus(1'b1, 6'h13, 32'h0);
    rd(6'h13, 32'h1, 32'h1);
    bus(1'b1, 6'h13, 32'h1);
    rd(6'h13, 32'h1, 32'h0);
    for (int n = 0; n < 50 && (rq.size() || fq.size()); n++) @(posedge MCLK);
    chk(n_rec == 1 && rq.size() == 0 && fq.size() == 0, "recovery or pending");
    $display("test hold done");
    test_done();
  end
endmodule : tb_can_error_count_and_id_filter
